// ### rtl/ccp_issue_port.v
// coprocessor and custom instruction issue port with AXI4-Lite register access
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`include "ccp_issue_map.vh"
`default_nettype none

module ccp_issue_port #(
  parameter NUM_COP = 8,
  parameter IMM_W = 13
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg cop_req_valid,
  output reg [2:0] cop_num,
  output reg [3:0] cop_kind,
  output reg [3:0] cop_first_op,
  output reg [2:0] cop_second_op,
  output reg [3:0] cop_dest_sel,
  output reg [3:0] cop_first_src_sel,
  output reg [3:0] cop_second_src_sel,
  output reg cop_acc,
  output reg [IMM_W-1:0] cop_imm,
  output reg [63:0] cop_wdata,
  output reg [63:0] cop_accum,
  input wire [NUM_COP-1:0] cop_present,
  input wire cop_resp_valid,
  input wire [63:0] cop_resp_data,
  output reg usage_fault
);

  localparam ST_IDLE = 2'd0;
  localparam ST_CHECK = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg [1:0] state_reg;
  reg [31:0] issue_reg;
  reg [31:0] oper_reg;
  reg [3:0] flags_reg;
  reg undef_reg;
  reg badreg_reg;
  reg done_reg;
  reg [31:0] gpr [0:`CCP_NUM_GPR-1];
  reg [7:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [7:0] raddr_reg;
  integer i;

  // byte-lane merge
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    begin
      merge = {strb[3] ? new_v[31:24] : old_v[31:24], strb[2] ? new_v[23:16] : old_v[23:16],
               strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
    end
  endfunction

  // operand fetch
  wire [3:0] kind = issue_reg[`CCP_ISS_KIND];
  wire [2:0] cop = issue_reg[`CCP_ISS_COP];
  wire acc = issue_reg[`CCP_ISS_ACC];
  wire [3:0] rlo = oper_reg[`CCP_OPR_RLO];
  wire [3:0] rhi = oper_reg[`CCP_OPR_RHI];
  wire [3:0] rsrc = oper_reg[`CCP_OPR_RSRC];
  wire big = oper_reg[`CCP_OPR_BIG];
  wire [3:0] rlo_p1 = rlo + 4'h1;
  wire is_pair = (kind == `CCP_K_CLS1_PAIR) || (kind == `CCP_K_CLS2_PAIR);
  wire is_single_cls = (kind == `CCP_K_CLS1) || (kind == `CCP_K_CLS2);
  wire is_cls2 = (kind == `CCP_K_CLS2) || (kind == `CCP_K_CLS2_PAIR);

  // code 1111 reads the flags in the top nibble rather than a register
  function [31:0] src_val;
    input [3:0] sel;
    begin
      if (sel == `CCP_REG_PC_OR_FLAGS) begin
        src_val = 32'h0;
        src_val[`CCP_FLAGS_POS] = flags_reg;
      end else begin
        src_val = gpr[sel];
      end
    end
  endfunction

  wire [31:0] lo_val = (rlo == `CCP_REG_PC_OR_FLAGS) ? 32'h0 : gpr[rlo];
  wire [31:0] hi_val = (rhi == `CCP_REG_PC_OR_FLAGS) ? 32'h0 : gpr[rhi];
  wire [31:0] lo_p1_val = (rlo_p1 == `CCP_REG_PC_OR_FLAGS) ? 32'h0 : gpr[rlo_p1];

  // checks that refuse the operation before it reaches the coprocessor
  reg bad_reg_sel;
  reg bad_kind;
  always @* begin
    bad_reg_sel = 1'b0;
    bad_kind = 1'b0;
    case (kind)
      `CCP_K_DATA_OP: bad_reg_sel = 1'b0;
      `CCP_K_TO_SINGLE: bad_reg_sel = (rlo == `CCP_REG_PC_OR_FLAGS);
      `CCP_K_FROM_SINGLE: bad_reg_sel = 1'b0; // 1111 is the flags target here
      `CCP_K_TO_DOUBLE: bad_reg_sel = (rlo == `CCP_REG_PC_OR_FLAGS) ||
                                      (rhi == `CCP_REG_PC_OR_FLAGS);
      `CCP_K_FROM_DOUBLE: bad_reg_sel = (rlo == `CCP_REG_PC_OR_FLAGS) ||
                                        (rhi == `CCP_REG_PC_OR_FLAGS);
      `CCP_K_CLS1, `CCP_K_CLS2: bad_reg_sel = 1'b0;
      `CCP_K_CLS1_PAIR, `CCP_K_CLS2_PAIR: bad_reg_sel = (rlo > `CCP_PAIR_FIRST_MAX);
      default: bad_kind = 1'b1;
    endcase
  end

  wire unit_missing = ~cop_present[cop];

  // outgoing data word
  reg [63:0] wdata_next;
  reg [63:0] accum_next;
  always @* begin
    wdata_next = 64'h0;
    accum_next = 64'h0;
    case (kind)
      `CCP_K_TO_SINGLE: wdata_next = {32'h0, lo_val};
      `CCP_K_TO_DOUBLE: wdata_next = {hi_val, lo_val};
      `CCP_K_CLS2, `CCP_K_CLS2_PAIR: wdata_next = {32'h0, src_val(rsrc)};
      default: wdata_next = 64'h0;
    endcase
    if (acc && is_single_cls) begin
      accum_next = {32'h0, src_val(rlo)};
    end else if (acc && is_pair) begin
      accum_next = big ? {lo_val, lo_p1_val} : {lo_p1_val, lo_val};
    end
  end

  // class one ignores the source operand; only immediate and accumulator matter
  wire [IMM_W-1:0] imm_next = (is_single_cls || is_pair) ?
    {oper_reg[`CCP_OPR_IMM_A], oper_reg[`CCP_OPR_IMM_B], oper_reg[`CCP_OPR_IMM_C]} : {IMM_W{1'b0}};

  wire [3:0] first_op_next = issue_reg[`CCP_ISS_OP1] &
    ((kind == `CCP_K_DATA_OP) ? `CCP_MASK_OP1_DATA : `CCP_MASK_OP1_XFER);

  // bus decode
  // register index is the word offset inside the register window
  wire [7:0] wofs = {waddr_reg[7:2], 2'b00};
  wire [7:0] rofs = {raddr_reg[7:2], 2'b00};
  wire w_is_gpr = (wofs >= `CCP_OFF_GPR_BASE) && (wofs <= `CCP_OFF_GPR_LAST);
  wire r_is_gpr = (rofs >= `CCP_OFF_GPR_BASE) && (rofs <= `CCP_OFF_GPR_LAST);
  wire [7:0] wgpr_ofs = wofs - `CCP_OFF_GPR_BASE;
  wire [7:0] rgpr_ofs = rofs - `CCP_OFF_GPR_BASE;
  wire [3:0] wgpr = wgpr_ofs[5:2];
  wire [3:0] rgpr = rgpr_ofs[5:2];
  wire w_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  wire r_fire = s_axi_arready && s_axi_arvalid;
  wire w_mapped = w_is_gpr || (wofs == `CCP_OFF_ISSUE) || (wofs == `CCP_OFF_OPERANDS) ||
                  (wofs == `CCP_OFF_STATUS) || (wofs == `CCP_OFF_FLAGS);
  // a new issue while one is in flight is refused rather than queued
  wire issue_wr = w_fire && (wofs == `CCP_OFF_ISSUE) && (state_reg == ST_IDLE);
  wire busy_wr = w_fire && (wofs == `CCP_OFF_ISSUE) && (state_reg != ST_IDLE);
  wire status_wr = w_fire && (wofs == `CCP_OFF_STATUS);

  always @* begin
    waddr_reg = s_axi_awaddr;
    wdata_reg = s_axi_wdata;
    wstrb_reg = s_axi_wstrb;
    raddr_reg = s_axi_araddr;
  end

  // write channel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCP_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (w_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (w_mapped && !busy_wr) ? `CCP_RESP_OKAY : `CCP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `CCP_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (r_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CCP_RESP_OKAY;
        s_axi_rdata <= 32'h0;
        if (r_is_gpr) begin
          s_axi_rdata <= gpr[rgpr];
        end else begin
          case (rofs)
            `CCP_OFF_ISSUE: s_axi_rdata <= issue_reg;
            `CCP_OFF_OPERANDS: s_axi_rdata <= oper_reg;
            `CCP_OFF_STATUS: s_axi_rdata <= {28'h0, done_reg, badreg_reg, undef_reg, state_reg != ST_IDLE};
            `CCP_OFF_FLAGS: s_axi_rdata <= {28'h0, flags_reg};
            default: s_axi_rresp <= `CCP_RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // issue sequencer
  wire finishing = (state_reg == ST_WAIT) && cop_resp_valid;
  wire refused = (state_reg == ST_CHECK) && (bad_kind || bad_reg_sel || unit_missing);
  wire launching = (state_reg == ST_CHECK) && !refused;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      issue_reg <= 32'h0;
      oper_reg <= 32'h0;
      undef_reg <= 1'b0;
      badreg_reg <= 1'b0;
      done_reg <= 1'b0;
      usage_fault <= 1'b0;
      cop_req_valid <= 1'b0;
      cop_num <= 3'h0;
      cop_kind <= 4'h0;
      cop_first_op <= 4'h0;
      cop_second_op <= 3'h0;
      cop_dest_sel <= 4'h0;
      cop_first_src_sel <= 4'h0;
      cop_second_src_sel <= 4'h0;
      cop_acc <= 1'b0;
      cop_imm <= {IMM_W{1'b0}};
      cop_wdata <= 64'h0;
      cop_accum <= 64'h0;
    end else begin
      usage_fault <= 1'b0;
      if (issue_wr) begin
        issue_reg <= merge(issue_reg, wdata_reg, wstrb_reg) & `CCP_ISS_MASK;
      end
      if (w_fire && (wofs == `CCP_OFF_OPERANDS) && (state_reg == ST_IDLE)) begin
        oper_reg <= merge(oper_reg, wdata_reg, wstrb_reg) & `CCP_OPR_MASK;
      end
      // sticky status: a hardware set in the same cycle beats a software clear
      if (status_wr && wstrb_reg[0] && wdata_reg[`CCP_ST_UNDEF]) undef_reg <= 1'b0;
      if (status_wr && wstrb_reg[0] && wdata_reg[`CCP_ST_BADREG]) badreg_reg <= 1'b0;
      if (status_wr && wstrb_reg[0] && wdata_reg[`CCP_ST_DONE]) done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (issue_wr) state_reg <= ST_CHECK;
        end
        ST_CHECK: begin
          if (refused) begin
            state_reg <= ST_IDLE;
            if (bad_kind || unit_missing) begin
              undef_reg <= 1'b1;
              usage_fault <= 1'b1;
            end else begin
              badreg_reg <= 1'b1;
            end
          end else begin
            state_reg <= ST_WAIT;
            cop_req_valid <= 1'b1;
            cop_num <= cop;
            cop_kind <= kind;
            cop_first_op <= first_op_next;
            cop_second_op <= issue_reg[`CCP_ISS_OP2];
            cop_dest_sel <= issue_reg[`CCP_ISS_CRD];
            cop_first_src_sel <= issue_reg[`CCP_ISS_CRN];
            cop_second_src_sel <= issue_reg[`CCP_ISS_CRM];
            cop_acc <= (is_single_cls || is_pair) ? acc : 1'b0;
            cop_imm <= imm_next;
            cop_wdata <= wdata_next;
            cop_accum <= accum_next;
          end
        end
        ST_WAIT: begin
          // the result itself is the datapath's business; only its placement is ours
          if (cop_resp_valid) begin
            state_reg <= ST_IDLE;
            cop_req_valid <= 1'b0;
            done_reg <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // core registers and write-back
  wire wb_single = (kind == `CCP_K_FROM_SINGLE) || is_single_cls;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 4'h0;
      for (i = 0; i < `CCP_NUM_GPR; i = i + 1) begin
        gpr[i] <= 32'h0;
      end
    end else begin
      if (w_fire && w_is_gpr) gpr[wgpr] <= merge(gpr[wgpr], wdata_reg, wstrb_reg);
      if (w_fire && (wofs == `CCP_OFF_FLAGS) && wstrb_reg[0]) flags_reg <= wdata_reg[3:0];
      // returned data beats a bus write to the same register
      if (finishing && wb_single) begin
        if (rlo == `CCP_REG_PC_OR_FLAGS) begin
          flags_reg <= cop_resp_data[`CCP_FLAGS_POS];
        end else begin
          gpr[rlo] <= cop_resp_data[31:0];
        end
      end
      if (finishing && (kind == `CCP_K_FROM_DOUBLE)) begin
        gpr[rlo] <= cop_resp_data[31:0];
        gpr[rhi] <= cop_resp_data[63:32];
      end
      if (finishing && is_pair) begin
        gpr[rlo] <= big ? cop_resp_data[63:32] : cop_resp_data[31:0];
        gpr[rlo_p1] <= big ? cop_resp_data[31:0] : cop_resp_data[63:32];
      end
    end
  end

endmodule // ccp_issue_port

`default_nettype wire

// ### shared/ccp_issue_map.vh
// register map, field positions and codes of the coprocessor issue port
`ifndef CCP_ISSUE_MAP_VH
`define CCP_ISSUE_MAP_VH

// register byte offsets
`define CCP_OFF_ISSUE 8'h00
`define CCP_OFF_OPERANDS 8'h04
`define CCP_OFF_STATUS 8'h08
`define CCP_OFF_FLAGS 8'h0C
`define CCP_OFF_GPR_BASE 8'h40
`define CCP_OFF_GPR_LAST 8'h78

// issue register fields
`define CCP_ISS_KIND 3:0
`define CCP_ISS_COP 6:4
`define CCP_ISS_ACC 7
`define CCP_ISS_OP1 11:8
`define CCP_ISS_OP2 14:12
`define CCP_ISS_CRD 18:15
`define CCP_ISS_CRN 22:19
`define CCP_ISS_CRM 26:23
`define CCP_ISS_MASK 32'h07FFFFFF

// operand register fields
`define CCP_OPR_RLO 3:0
`define CCP_OPR_RHI 7:4
`define CCP_OPR_RSRC 11:8
`define CCP_OPR_BIG 12
`define CCP_OPR_IMM_A 18:13
`define CCP_OPR_IMM_B 19
`define CCP_OPR_IMM_C 25:20
`define CCP_OPR_MASK 32'h03FFFFFF

// status register bits
`define CCP_ST_BUSY 0
`define CCP_ST_UNDEF 1
`define CCP_ST_BADREG 2
`define CCP_ST_DONE 3

// operation kinds
`define CCP_K_DATA_OP 4'h0
`define CCP_K_TO_SINGLE 4'h1
`define CCP_K_FROM_SINGLE 4'h2
`define CCP_K_TO_DOUBLE 4'h3
`define CCP_K_FROM_DOUBLE 4'h4
`define CCP_K_CLS1 4'h5
`define CCP_K_CLS1_PAIR 4'h6
`define CCP_K_CLS2 4'h7
`define CCP_K_CLS2_PAIR 4'h8

// register numbers and limits
`define CCP_REG_PC_OR_FLAGS 4'hF
`define CCP_PAIR_FIRST_MAX 4'hA
`define CCP_NUM_GPR 15
`define CCP_FLAGS_POS 31:28
`define CCP_MASK_OP1_XFER 4'h7
`define CCP_MASK_OP1_DATA 4'hF

// bus answers
`define CCP_RESP_OKAY 2'b00
`define CCP_RESP_SLVERR 2'b10

`endif

// ### sim/ccp_issue_port_monitor.sv
// concurrent checks on the issue port top-level pins
`include "ccp_issue_map.vh"
`default_nettype none
module ccp_issue_port_monitor #(
  parameter NUM_COP = 8,
  parameter IMM_W = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic cop_req_valid,
  input wire logic [2:0] cop_num,
  input wire logic [3:0] cop_kind,
  input wire logic [3:0] cop_first_op,
  input wire logic cop_acc,
  input wire logic [IMM_W-1:0] cop_imm,
  input wire logic [63:0] cop_wdata,
  input wire logic [63:0] cop_accum,
  input wire logic [NUM_COP-1:0] cop_present,
  input wire logic cop_resp_valid,
  input wire logic usage_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_fault_no_req; usage_fault |-> !cop_req_valid; endproperty
  a_fault_no_req: assert property (p_fault_no_req) else $error("fault while request up");
  property p_fault_pulse; usage_fault |=> !usage_fault; endproperty
  a_fault_pulse: assert property (p_fault_pulse) else $error("fault longer than one cycle");
  property p_present; cop_req_valid |-> cop_present[cop_num]; endproperty
  a_present: assert property (p_present) else $error("request to absent unit");
  property p_kind; cop_req_valid |-> cop_kind <= `CCP_K_CLS2_PAIR; endproperty
  a_kind: assert property (p_kind) else $error("request with unknown kind");
  property p_hold; cop_req_valid && !cop_resp_valid |=> cop_req_valid && $stable(cop_wdata) && $stable(cop_num);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before answer");
  property p_drop; cop_req_valid && cop_resp_valid |=> !cop_req_valid; endproperty
  a_drop: assert property (p_drop) else $error("request not released after answer");
  property p_xfer_op; cop_req_valid && cop_kind inside {[4'h1:4'h4]} |-> !cop_first_op[3]; endproperty
  a_xfer_op: assert property (p_xfer_op) else $error("transfer opcode wider than three bits");
  property p_data_op; cop_req_valid && cop_kind == `CCP_K_DATA_OP |-> cop_wdata == 64'h0 && cop_accum == 64'h0;
  endproperty
  a_data_op: assert property (p_data_op) else $error("data op moved core data");
  property p_plain; cop_req_valid && !cop_acc |-> cop_accum == 64'h0; endproperty
  a_plain: assert property (p_plain) else $error("plain form carried accumulator");
  property p_imm; cop_req_valid && cop_kind < `CCP_K_CLS1 |-> cop_imm == 0 && !cop_acc; endproperty
  a_imm: assert property (p_imm) else $error("immediate on non-custom kind");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
endmodule // ccp_issue_port_monitor
bind ccp_issue_port ccp_issue_port_monitor #(.NUM_COP(NUM_COP), .IMM_W(IMM_W)) u_mon (.clk(clk), .rst_n(rst_n),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .cop_req_valid(cop_req_valid), .cop_num(cop_num),
  .cop_kind(cop_kind), .cop_first_op(cop_first_op), .cop_acc(cop_acc), .cop_imm(cop_imm), .cop_wdata(cop_wdata),
  .cop_accum(cop_accum), .cop_present(cop_present), .cop_resp_valid(cop_resp_valid), .usage_fault(usage_fault));
`default_nettype wire

// ### sim/ccp_cop_model.sv
// behavioural custom datapath answering issue requests
`default_nettype none
module ccp_cop_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic cop_req_valid,
  input wire logic [2:0] cop_num,
  input wire logic [12:0] cop_imm,
  input wire logic [63:0] cop_wdata,
  input wire logic [63:0] cop_accum,
  output logic cop_resp_valid,
  output logic [63:0] cop_resp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic answered;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      answered <= 1'b0;
      cop_resp_valid <= 1'b0;
      cop_resp_data <= 64'h0;
    end else begin
      cop_resp_valid <= 1'b0;
      // data toggles outside the answer so stale values never pass
      cop_resp_data <= ~cop_resp_data;
      if (!cop_req_valid) begin
        cnt <= 4'h0;
        answered <= 1'b0;
      end else if (!answered) begin
        if (cnt == (slow ? 4'h4 : 4'h0)) begin
          cop_resp_valid <= 1'b1;
          answered <= 1'b1;
          // unit-specific function of operands and number
          cop_resp_data <= {cop_accum[63:32] ^ 32'h5A5A0F0F,
            cop_wdata[31:0] ^ cop_accum[31:0] ^ {16'hF0A5, 3'h0, cop_imm} ^ {29'h0, cop_num}};
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // ccp_cop_model
`default_nettype wire

// ### sim/coprocessor_custom_instr_port_tb.sv
// register-level tests of the coprocessor issue port
`include "ccp_issue_map.vh"
`default_nettype none
module coprocessor_custom_instr_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, present = 8'hF7;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  wire awready, wready, bvalid, arready, rvalid, req, acc, rv, uf_w;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] num, op2;
  wire [3:0] kind, op1, dsel, s1, s2;
  wire [12:0] imm;
  wire [63:0] cw, ca, rsp;
  int n_errors = 0, n_checks = 0;
  logic seen, uf, lag = 1'b0;
  logic [26:0] sf;
  logic [63:0] sw, sa, r;
  logic [12:0] si;
  logic [31:0] g [0:14];
  logic [3:0] fl;
  ccp_issue_port dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cop_req_valid(req), .cop_num(num), .cop_kind(kind),
    .cop_first_op(op1), .cop_second_op(op2), .cop_dest_sel(dsel), .cop_first_src_sel(s1),
    .cop_second_src_sel(s2), .cop_acc(acc), .cop_imm(imm), .cop_wdata(cw), .cop_accum(ca),
    .cop_present(present), .cop_resp_valid(rv), .cop_resp_data(rsp), .usage_fault(uf_w));
  ccp_cop_model partner (.clk(clk), .rst_n(rst_n), .slow(slow), .cop_req_valid(req), .cop_num(num),
    .cop_imm(imm), .cop_wdata(cw), .cop_accum(ca), .cop_resp_valid(rv), .cop_resp_data(rsp));
  always #2 clk = ~clk;
  function automatic logic [31:0] iss(logic [3:0] k, logic [2:0] c, logic a, logic [3:0] o1, logic [2:0] o2,
    logic [3:0] d, logic [3:0] n, logic [3:0] m);
    return {5'h0, m, n, d, o2, o1, a, c, k};
  endfunction
  function automatic logic [31:0] ops(logic [3:0] lo, logic [3:0] hi, logic [3:0] src, logic big);
    return {19'h0, big, src, hi, lo};
  endfunction
  function automatic logic [63:0] mres(logic [2:0] n, logic [63:0] w, logic [63:0] a, logic [12:0] im);
    return {a[63:32] ^ 32'h5A5A0F0F, w[31:0] ^ a[31:0] ^ {16'hF0A5, 3'h0, im} ^ {29'h0, n}};
  endfunction
  function automatic logic [7:0] gad(logic [3:0] n);
    return `CCP_OFF_GPR_BASE + {2'b00, n, 2'b00};
  endfunction
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // a late bready makes the slave hold its answer
    bready <= !lag;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
    end while (bvalid !== 1'b1 || bready !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rresp, er);
    if (er == `CCP_RESP_OKAY) chk(rdata, e);
  endtask
  // operands then issue; snapshot the request while it stands
  task automatic op(input logic [31:0] o, input logic [31:0] i);
    wr(`CCP_OFF_OPERANDS, o, `CCP_RESP_OKAY);
    wr(`CCP_OFF_ISSUE, i, `CCP_RESP_OKAY);
    seen = 1'b0;
    uf = 1'b0;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      if (uf_w === 1'b1) uf = 1'b1;
      if (req === 1'b1) begin
        seen = 1'b1;
        sf = {num, kind, op1, op2, dsel, s1, s2, acc};
        sw = cw;
        sa = ca;
        si = imm;
      end else if (seen) break;
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`CCP_OFF_STATUS, `CCP_RESP_OKAY, 32'h0);
    rd(8'h20, `CCP_RESP_SLVERR, 32'h0);
    for (int n = 0; n < 15; n++) begin
      g[n] = 32'h13579BDF ^ {4{n[7:0]}};
      wr(gad(n[3:0]), g[n], `CCP_RESP_OKAY);
    end
    for (int n = 0; n < 15; n++) rd(gad(n[3:0]), `CCP_RESP_OKAY, g[n]);
    fl = 4'h9;
    wr(`CCP_OFF_FLAGS, {28'h0, fl}, `CCP_RESP_OKAY);
    op(ops(4'h3, 4'h0, 4'h0, 1'b0), iss(4'h1, 3'd2, 1'b0, 4'hD, 3'h6, 4'h1, 4'h2, 4'h3));
    chk(sf, {3'd2, 4'h1, 4'h5, 3'h6, 4'h1, 4'h2, 4'h3, 1'b0});
    chk(sw, {32'h0, g[3]});
    op(ops(4'h0, 4'h0, 4'h0, 1'b0), iss(4'h0, 3'd7, 1'b0, 4'hD, 3'h1, 4'hE, 4'hC, 4'hB));
    chk(sf, {3'd7, 4'h0, 4'hD, 3'h1, 4'hE, 4'hC, 4'hB, 1'b0});
    chk({sw, sa}, 128'h0);
    slow <= 1'b1;
    op(ops(4'h5, 4'h0, 4'h0, 1'b0), iss(4'h2, 3'd1, 1'b0, 4'h2, 3'h0, 4'h0, 4'h1, 4'h1));
    r = mres(3'd1, 64'h0, 64'h0, 13'h0);
    rd(gad(4'h5), `CCP_RESP_OKAY, r[31:0]);
    op(ops(4'hF, 4'h0, 4'h0, 1'b0), iss(4'h2, 3'd4, 1'b0, 4'h2, 3'h0, 4'h0, 4'h1, 4'h1));
    r = mres(3'd4, 64'h0, 64'h0, 13'h0);
    fl = r[31:28];
    rd(`CCP_OFF_FLAGS, `CCP_RESP_OKAY, {28'h0, fl});
    slow <= 1'b0;
    op(ops(4'h1, 4'h2, 4'h0, 1'b0), iss(4'h3, 3'd0, 1'b0, 4'h7, 3'h0, 4'h0, 4'h0, 4'h5));
    chk(sw, {g[2], g[1]});
    op(ops(4'h1, 4'hF, 4'h0, 1'b0), iss(4'h3, 3'd0, 1'b0, 4'h7, 3'h0, 4'h0, 4'h0, 4'h5));
    chk(seen, 1'b0);
    rd(`CCP_OFF_STATUS, `CCP_RESP_OKAY, 32'hC);
    lag = 1'b1;
    wr(`CCP_OFF_STATUS, 32'hF, `CCP_RESP_OKAY);
    lag = 1'b0;
    rd(`CCP_OFF_STATUS, `CCP_RESP_OKAY, 32'h0);
    op(ops(4'h6, 4'h7, 4'h0, 1'b0), iss(4'h4, 3'd5, 1'b0, 4'h3, 3'h0, 4'h0, 4'h0, 4'h2));
    r = mres(3'd5, 64'h0, 64'h0, 13'h0);
    rd(gad(4'h6), `CCP_RESP_OKAY, r[31:0]);
    rd(gad(4'h7), `CCP_RESP_OKAY, r[63:32]);
    op({6'h15, 1'b1, 6'h2A, 1'b0, 4'h0, 4'h0, 4'h4}, iss(4'h5, 3'd6, 1'b1, 4'h0, 3'h0, 4'h0, 4'h0, 4'h0));
    chk({si, sf[0]}, {6'h2A, 1'b1, 6'h15, 1'b1});
    chk(sa, {32'h0, g[4]});
    r = mres(3'd6, 64'h0, {32'h0, g[4]}, {6'h2A, 1'b1, 6'h15});
    g[4] = r[31:0];
    rd(gad(4'h4), `CCP_RESP_OKAY, g[4]);
    op(ops(4'h8, 4'h0, 4'h0, 1'b1), iss(4'h6, 3'd1, 1'b1, 4'h0, 3'h0, 4'h0, 4'h0, 4'h0));
    chk(sa, {g[8], g[9]});
    r = mres(3'd1, 64'h0, {g[8], g[9]}, 13'h0);
    rd(gad(4'h8), `CCP_RESP_OKAY, r[63:32]);
    rd(gad(4'h9), `CCP_RESP_OKAY, r[31:0]);
    op(ops(4'hB, 4'h0, 4'h0, 1'b0), iss(4'h6, 3'd1, 1'b0, 4'h0, 3'h0, 4'h0, 4'h0, 4'h0));
    chk(seen, 1'b0);
    op(ops(4'hF, 4'h0, 4'hF, 1'b0), iss(4'h7, 3'd0, 1'b0, 4'h0, 3'h0, 4'h0, 4'h0, 4'h0));
    chk(sw, {32'h0, fl, 28'h0});
    r = mres(3'd0, {32'h0, fl, 28'h0}, 64'h0, 13'h0);
    rd(`CCP_OFF_FLAGS, `CCP_RESP_OKAY, {28'h0, r[31:28]});
    op(ops(4'h2, 4'h0, 4'h3, 1'b0), iss(4'h8, 3'd2, 1'b0, 4'h0, 3'h0, 4'h0, 4'h0, 4'h0));
    chk(sw, {32'h0, g[3]});
    r = mres(3'd2, {32'h0, g[3]}, 64'h0, 13'h0);
    rd(gad(4'h2), `CCP_RESP_OKAY, r[31:0]);
    op(ops(4'h0, 4'h0, 4'h0, 1'b0), iss(4'h1, 3'd3, 1'b0, 4'h0, 3'h0, 4'h0, 4'h0, 4'h0));
    chk({seen, uf}, 2'b01);
    op(ops(4'h0, 4'h0, 4'h0, 1'b0), iss(4'h9, 3'd0, 1'b0, 4'h0, 3'h0, 4'h0, 4'h0, 4'h0));
    chk({seen, uf}, 2'b01);
    rd(`CCP_OFF_STATUS, `CCP_RESP_OKAY, 32'hE);
    close_out();
  end
endmodule // coprocessor_custom_instr_port_tb
`default_nettype wire
